/* File: rtl/lock_ctrl_pkg.sv */
// constants shared by the serial control port and its lock-status logic
package lock_ctrl_pkg;
  localparam logic [7:0] lock_status_addr        = 8'h06;
  localparam logic [7:0] recovery_control_addr   = 8'h08;
  localparam logic [7:0] lock_signal_config_addr = 8'h09;
  localparam logic [7:0] reference_buffer_addr   = 8'h0a;
  localparam logic [7:0] output_driver_addr      = 8'h1e;
  localparam logic [7:0] highest_addr            = 8'h1e;
  localparam logic [5:0] bus_addr_upper          = 6'h20;
  localparam int         sticky_clear_bit        = 2;
  localparam int         rate_measure_bit        = 1;
  localparam int         mode_lsb                = 4;
  localparam int         indicator_mode_bit      = 4;
  localparam int         ref_pdwn_bit            = 2;
  localparam int         squelch_bit             = 5;
  localparam int         data_off_bit            = 4;
  localparam int         clock_off_bit           = 3;
  localparam int         polarity_bit            = 1;
  localparam int         sticky_status_bit       = 2;
  localparam logic [2:0] mode_reference_locked   = 3'h2;
  localparam logic [7:0] recovery_control_rst    = 8'h00;
  localparam logic [7:0] lock_signal_config_rst  = 8'h00;
  localparam logic [7:0] reference_buffer_rst    = 8'h05;
  localparam logic [7:0] output_driver_rst       = 8'h00;
  // harmonic detection bound: 2^16 bit periods over transition density
  localparam int         harmonic_log2_periods   = 16;
endpackage

/* File: rtl/sync2.sv */
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
module sync2 (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic d_in,
  output logic      q_out
);
  logic meta_reg;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_reg <= 1'b0;
      q_out    <= 1'b0;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule

/* File: rtl/serial_control_lock_status.sv */
// two-wire serial control port with lock-status, harmonic and output control
`timescale 1ns/1ps
module serial_control_lock_status
  import lock_ctrl_pkg::*;
(
  // system
  input  wire logic  mclk_in,
  input  wire logic  sys_rst_in,
  // serial bus pins, clock from master
  input  wire logic  scl_in,
  input  wire logic  sda_in,
  output logic       sda_out,
  output logic       sda_oe_n_out,
  input  wire logic  addr_select_in,
  // recovery core, link domain
  input  wire logic  link_clk_in,
  input  wire logic  acquiring_in,
  input  wire logic  harmonic_seen_in,
  output logic       force_acquire_out,
  // recovery core, system domain
  input  wire logic  rate_measure_done_in,
  input  wire logic  recovered_data_in,
  // pins and controls
  output logic       lock_lost_indicator_out,
  output logic       recovered_data_out,
  output logic       data_driver_off_out,
  output logic       clock_driver_off_out,
  output logic [2:0] recovery_mode_select_out,
  output logic       rate_measure_enable_out,
  output logic       reference_buffer_powerdown_out
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic scl_s, sda_s, adr_s, acq_s;
  sync2 u_scl (
    .clk_in (mclk_in),
    .rst_in (sys_rst_in),
    .d_in   (scl_in),
    .q_out  (scl_s)
  );
  sync2 u_sda (
    .clk_in (mclk_in),
    .rst_in (sys_rst_in),
    .d_in   (sda_in),
    .q_out  (sda_s)
  );
  sync2 u_adr (
    .clk_in (mclk_in),
    .rst_in (sys_rst_in),
    .d_in   (addr_select_in),
    .q_out  (adr_s)
  );
  sync2 u_acq (
    .clk_in (mclk_in),
    .rst_in (sys_rst_in),
    .d_in   (acquiring_in),
    .q_out  (acq_s)
  );

  logic scl_d_reg, sda_d_reg;
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end
  wire scl_rise  = scl_s & ~scl_d_reg;
  wire scl_fall  = ~scl_s & scl_d_reg;
  wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] recovery_control_reg, lock_signal_config_reg;
  logic [7:0] reference_buffer_control_reg, output_driver_control_reg;
  logic       sticky_reg, clear_armed_reg, lock_lost_live_reg;

  function automatic logic valid_sub(input logic [7:0] a);
    valid_sub = (a == lock_status_addr) || (a == recovery_control_addr) ||
                (a == lock_signal_config_addr) || (a == reference_buffer_addr) ||
                (a == output_driver_addr);
  endfunction

  logic [7:0] sub_reg;
  wire [7:0] lock_status_val = {5'h00, sticky_reg, 1'b0, rate_measure_done_in};
  logic [7:0] rd_val;
  always_comb begin
    case (sub_reg)
      lock_status_addr:        rd_val = lock_status_val;
      recovery_control_addr:   rd_val = recovery_control_reg;
      lock_signal_config_addr: rd_val = lock_signal_config_reg;
      reference_buffer_addr:   rd_val = reference_buffer_control_reg;
      output_driver_addr:      rd_val = output_driver_control_reg;
      default:                 rd_val = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // serial slave state machine
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    st_idle  = 3'b000,
    st_addr  = 3'b001,
    st_aack  = 3'b010,
    st_sub   = 3'b011,
    st_wdata = 3'b100,
    st_wack  = 3'b101,
    st_rdata = 3'b110,
    st_rack  = 3'b111
  } bus_state_type;

  bus_state_type state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic       rw_reg, ack_ok_reg, have_sub_reg, drive_low_reg;
  logic       wr_pulse;
  logic [7:0] wr_addr, wr_data;

  wire [6:0] my_addr   = {bus_addr_upper, adr_s};
  wire       addr_hit  = (shift_reg[7:1] == my_addr);
  wire       sub_valid = valid_sub(shift_reg);
  wire [7:0] sub_inc   = (sub_reg >= highest_addr) ? highest_addr : sub_reg + 8'h01;

  assign wr_pulse = (state_reg == st_wdata) && scl_fall && (bit_cnt_reg == 4'h8);
  assign wr_addr  = sub_reg;
  assign wr_data  = shift_reg;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg     <= st_idle;
      bit_cnt_reg   <= 4'h0;
      shift_reg     <= 8'h00;
      sub_reg       <= 8'h00;
      rw_reg        <= 1'b0;
      ack_ok_reg    <= 1'b0;
      have_sub_reg  <= 1'b0;
      drive_low_reg <= 1'b0;
    end else if (start_det) begin
      state_reg     <= st_addr;
      bit_cnt_reg   <= 4'h0;
      have_sub_reg  <= 1'b0;
      drive_low_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg     <= st_idle;
      drive_low_reg <= 1'b0;
    end else begin
      case (state_reg)
        st_idle: drive_low_reg <= 1'b0;
        st_addr, st_sub, st_wdata: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == 4'h8) begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == st_addr) begin
              rw_reg        <= shift_reg[0];
              ack_ok_reg    <= addr_hit;
              drive_low_reg <= addr_hit;
              state_reg     <= addr_hit ? st_aack : st_idle;
            end else if (state_reg == st_sub) begin
              ack_ok_reg    <= sub_valid;
              drive_low_reg <= sub_valid;
              sub_reg       <= shift_reg;
              have_sub_reg  <= 1'b1;
              state_reg     <= sub_valid ? st_wack : st_idle;
            end else begin
              drive_low_reg <= 1'b1;
              sub_reg       <= sub_inc;
              state_reg     <= st_wack;
            end
          end
        end
        st_aack, st_wack: begin
          if (scl_fall) begin
            drive_low_reg <= 1'b0;
            if (state_reg == st_aack && rw_reg) begin
              state_reg     <= st_rdata;
              shift_reg     <= rd_val;
              drive_low_reg <= ~rd_val[7];
              bit_cnt_reg   <= 4'h1;
            end else begin
              state_reg <= have_sub_reg ? st_wdata : st_sub;
            end
          end
        end
        st_rdata: begin
          if (scl_fall) begin
            if (bit_cnt_reg == 4'h8) begin
              drive_low_reg <= 1'b0;
              sub_reg       <= sub_inc;
              state_reg     <= st_rack;
            end else begin
              shift_reg     <= {shift_reg[6:0], 1'b0};
              drive_low_reg <= ~shift_reg[6];
              bit_cnt_reg   <= bit_cnt_reg + 4'h1;
            end
          end
        end
        st_rack: begin
          if (scl_rise) begin
            ack_ok_reg <= ~sda_s;
          end else if (scl_fall) begin
            if (ack_ok_reg) begin
              state_reg     <= st_rdata;
              shift_reg     <= rd_val;
              drive_low_reg <= ~rd_val[7];
              bit_cnt_reg   <= 4'h1;
            end else begin
              state_reg <= st_idle;
            end
          end
        end
        default: state_reg <= st_idle;
      endcase
    end
  end

  assign sda_out      = 1'b0;
  assign sda_oe_n_out = ~drive_low_reg;

  // ---------------------------------------------------------------
  // register writes and sticky flag
  // ---------------------------------------------------------------
  wire lock_loss_evt = acq_s & ~lock_lost_live_reg;
  wire clear_now     = wr_pulse && (wr_addr == recovery_control_addr) &&
                       clear_armed_reg && !wr_data[sticky_clear_bit];

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      recovery_control_reg         <= recovery_control_rst;
      lock_signal_config_reg       <= lock_signal_config_rst;
      reference_buffer_control_reg <= reference_buffer_rst;
      output_driver_control_reg    <= output_driver_rst;
      clear_armed_reg              <= 1'b0;
      sticky_reg                   <= 1'b0;
      lock_lost_live_reg           <= 1'b0;
    end else begin
      lock_lost_live_reg <= acq_s;
      if (wr_pulse) begin
        case (wr_addr)
          recovery_control_addr: begin
            recovery_control_reg <= wr_data;
            clear_armed_reg      <= wr_data[sticky_clear_bit];
          end
          lock_signal_config_addr: lock_signal_config_reg       <= wr_data;
          reference_buffer_addr:   reference_buffer_control_reg <= wr_data;
          output_driver_addr:      output_driver_control_reg    <= wr_data;
          default: ;
        endcase
      end
      // event beats the clear in the same cycle
      if (lock_loss_evt) begin
        sticky_reg <= 1'b1;
      end else if (clear_now) begin
        sticky_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // control outputs
  // ---------------------------------------------------------------
  wire ref_locked = recovery_control_reg[mode_lsb +: 3] == mode_reference_locked;
  assign recovery_mode_select_out       = recovery_control_reg[mode_lsb +: 3];
  assign rate_measure_enable_out        = recovery_control_reg[rate_measure_bit];
  assign reference_buffer_powerdown_out = reference_buffer_control_reg[ref_pdwn_bit];
  // live state follows acquisition from the core, which holds the ppm hysteresis
  wire lol_sel = lock_signal_config_reg[indicator_mode_bit] ?
                 sticky_reg : acq_s;
  wire d_off   = output_driver_control_reg[data_off_bit];
  wire dat_sel = output_driver_control_reg[squelch_bit] ?
                 output_driver_control_reg[polarity_bit] :
                 (recovered_data_in ^ output_driver_control_reg[polarity_bit]);

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lock_lost_indicator_out <= 1'b0;
      recovered_data_out      <= 1'b0;
      data_driver_off_out     <= 1'b0;
      clock_driver_off_out    <= 1'b0;
    end else begin
      lock_lost_indicator_out <= lol_sel;
      recovered_data_out      <= d_off ? 1'b0 : dat_sel;
      data_driver_off_out     <= d_off;
      clock_driver_off_out    <= d_off | output_driver_control_reg[clock_off_bit];
    end
  end

  // ---------------------------------------------------------------
  // harmonic detector, link domain
  // ---------------------------------------------------------------
  // mode level crosses in, kept at link rate so a rate change is seen within 2^16 periods
  logic ref_locked_l;
  sync2 u_mode (
    .clk_in (link_clk_in),
    .rst_in (sys_rst_in),
    .d_in   (ref_locked),
    .q_out  (ref_locked_l)
  );
  logic harm_s;
  sync2 u_harm (
    .clk_in (link_clk_in),
    .rst_in (sys_rst_in),
    .d_in   (harmonic_seen_in),
    .q_out  (harm_s)
  );

  always_ff @(posedge link_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      force_acquire_out <= 1'b0;
    end else begin
      force_acquire_out <= harm_s & ~ref_locked_l;
    end
  end
endmodule

/* File: tb/serial_control_lock_status_chk.sv */
// port checker for the serial control and lock-status block
`timescale 1ns/1ps
module serial_control_lock_status_chk
  import lock_ctrl_pkg::*;
(
  // clocks and reset
  input wire logic       mclk_in,
  input wire logic       link_clk_in,
  input wire logic       sys_rst_in,
  // watched ports
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n_out,
  input wire logic       acquiring_in,
  input wire logic       harmonic_seen_in,
  input wire logic       force_acquire_out,
  input wire logic       lock_lost_indicator_out,
  input wire logic       recovered_data_out,
  input wire logic       data_driver_off_out,
  input wire logic       clock_driver_off_out,
  input wire logic [2:0] recovery_mode_select_out,
  input wire logic       reference_buffer_powerdown_out
);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  clk_follow_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    data_driver_off_out |-> clock_driver_off_out) else $error("clock driver left on");
  data_quiet_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    data_driver_off_out && $past(data_driver_off_out) |-> !recovered_data_out)
    else $error("data moves while driver off");
  sda_low_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    $fell(sda_oe_n_out) |-> (!sda_out && !sda_oe_n_out) [*8])
    else $error("data line drive too short");
  drive_edge_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    $changed(sda_oe_n_out) |-> !scl_in) else $error("data drive changed in clock high");
  lol_raise_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    $rose(acquiring_in) ##1 acquiring_in [*3] |-> ##[0:3] lock_lost_indicator_out)
    else $error("lock lost pin stayed low");
  ref_reset_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    $fell(sys_rst_in) |-> reference_buffer_powerdown_out) else $error("buffer on at reset");
  harm_gate_a: assert property (@(posedge link_clk_in) disable iff (sys_rst_in)
    (recovery_mode_select_out == mode_reference_locked) [*5] |-> !force_acquire_out)
    else $error("harmonic acts in reference mode");
  harm_force_a: assert property (@(posedge link_clk_in) disable iff (sys_rst_in)
    (harmonic_seen_in && recovery_mode_select_out != mode_reference_locked) [*5]
    |-> force_acquire_out) else $error("harmonic not acted on");
  cover property (@(posedge mclk_in) !sda_oe_n_out);
  cover property (@(posedge link_clk_in) force_acquire_out);
  cover property (@(posedge mclk_in) data_driver_off_out);
endmodule

bind serial_control_lock_status serial_control_lock_status_chk chk_i (
  .mclk_in(mclk_in), .link_clk_in(link_clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl_in),
  .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .acquiring_in(acquiring_in),
  .harmonic_seen_in(harmonic_seen_in), .force_acquire_out(force_acquire_out),
  .lock_lost_indicator_out(lock_lost_indicator_out), .recovered_data_out(recovered_data_out),
  .data_driver_off_out(data_driver_off_out), .clock_driver_off_out(clock_driver_off_out),
  .recovery_mode_select_out(recovery_mode_select_out),
  .reference_buffer_powerdown_out(reference_buffer_powerdown_out));

/* File: tb/i2c_master_model.sv */
// two-wire bus master model with a pulled-up data wire
`timescale 1ns/1ps
module i2c_master_model (
  // clock
  input  wire logic clk_in,
  // device side of the data wire
  input  wire logic dev_oe_n_in,
  input  wire logic dev_sda_in,
  // bus wires
  output logic      scl_out,
  output logic      sda_out
);
  logic m_sda;
  // released wire floats high through the pull-up
  assign sda_out = m_sda & (dev_oe_n_in | dev_sda_in);
  initial begin
    scl_out = 1'b1;
    m_sda = 1'b1;
  end
  // ----------------------------------------
  // bus phases, 6 clocks each so both clock phases exceed 5
  // ----------------------------------------
  task automatic qb();
    repeat (6) @(negedge clk_in);
  endtask
  task automatic start(); // one start per high phase
    m_sda = 1'b1;
    qb();
    scl_out = 1'b1;
    qb();
    m_sda = 1'b0;
    qb();
    scl_out = 1'b0;
    qb();
  endtask
  task automatic stop(); // every transfer closes here
    m_sda = 1'b0;
    qb();
    scl_out = 1'b1;
    qb();
    m_sda = 1'b1;
    qb();
  endtask
  task automatic bit_x(input logic b, output logic r);
    m_sda = b;
    qb();
    scl_out = 1'b1;
    qb();
    r = sda_out;
    qb();
    scl_out = 1'b0;
    qb();
  endtask
  // msb first; ninth bit carries the master's ack or nack
  task automatic xfer(input logic [7:0] d, input logic ma, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(ma, ack);
  endtask
endmodule

/* File: tb/serial_control_lock_status_tb.sv */
// self-checking bench for the serial control and lock-status block
`timescale 1ns/1ps
module serial_control_lock_status_tb;
  import lock_ctrl_pkg::*;
  logic       mclk = 1'b0, lclk = 1'b0, rst = 1'b1, sel = 1'b0;
  logic       acq = 1'b0, harm = 1'b0, rdone = 1'b1, rdata = 1'b1;
  logic       scl, sda, sda_o, oe_n, frc, lock_lost_indicator, dout, doff, coff, rme, rpd, ack;
  logic [2:0] mode;
  logic [7:0] q;
  logic [7:0] ov [5] = '{8'h10, 8'h08, 8'h20, 8'h22, 8'h02};
  logic [7:0] ex [5] = '{8'h06, 8'h03, 8'h00, 8'h01, 8'h00};
  int         mismatches = 0;
  int         n_checks = 0;
  always #50 mclk = ~mclk;
  // odd offset keeps link edges off the system clock edges
  initial #13 forever #80 lclk = ~lclk;
  serial_control_lock_status dut (
    .mclk_in(mclk), .sys_rst_in(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
    .sda_oe_n_out(oe_n), .addr_select_in(sel), .link_clk_in(lclk), .acquiring_in(acq),
    .harmonic_seen_in(harm), .force_acquire_out(frc), .rate_measure_done_in(rdone),
    .recovered_data_in(rdata), .lock_lost_indicator_out(lock_lost_indicator), .recovered_data_out(dout),
    .data_driver_off_out(doff), .clock_driver_off_out(coff),
    .recovery_mode_select_out(mode), .rate_measure_enable_out(rme),
    .reference_buffer_powerdown_out(rpd));
  i2c_master_model m (.clk_in(mclk), .dev_oe_n_in(oe_n), .dev_sda_in(sda_o), .scl_out(scl),
    .sda_out(sda));
  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic probe(input logic [7:0] b0, input logic [7:0] b1, input int n);
    m.start();
    m.xfer(b0, 1'b1, q, ack);
    if (n > 1) m.xfer(b1, 1'b1, q, ack);
    m.stop();
  endtask
  task automatic wr(input logic [7:0] sub, input logic [7:0] d0, input logic [7:0] d1,
                    input int n);
    m.start();
    m.xfer({bus_addr_upper, sel, 1'b0}, 1'b1, q, ack);
    m.xfer(sub, 1'b1, q, ack);
    m.xfer(d0, 1'b1, q, ack);
    if (n > 1) m.xfer(d1, 1'b1, q, ack);
    m.stop();
    chk({7'h0, ack}, 8'h00);
    repeat (4) @(negedge mclk);
  endtask
  // pointer write, then a fresh start; nack ends the read
  task automatic rd(input logic [7:0] sub, input int n);
    probe({bus_addr_upper, sel, 1'b0}, sub, 2);
    m.start();
    m.xfer({bus_addr_upper, sel, 1'b1}, 1'b1, q, ack);
    for (int i = 0; i < n; i++) m.xfer(8'hff, i == n - 1, q, ack);
    m.stop();
  endtask
  task automatic pulse(input logic [7:0] hi, input logic [7:0] lo);
    acq = 1'b1;
    repeat (8) @(negedge mclk);
    chk({7'h0, lock_lost_indicator}, hi);
    acq = 1'b0;
    repeat (8) @(negedge mclk);
    chk({7'h0, lock_lost_indicator}, lo);
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #6000000;
    mismatches++;
    report_and_stop();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    repeat (6) @(negedge mclk);
    chk({7'h0, rpd}, 8'h01);
    rd(recovery_control_addr, 3);
    chk(q, reference_buffer_rst);
    for (int s = 0; s < 2; s++) begin
      sel = s[0];
      probe({bus_addr_upper, ~sel, 1'b0}, 8'h00, 1);
      chk({7'h0, ack}, 8'h01);
      probe({bus_addr_upper, sel, 1'b0}, 8'h07, 2);
      chk({7'h0, ack}, 8'h01);
      wr(lock_signal_config_addr, 8'h5a, 8'h00, 1);
      rd(lock_signal_config_addr, 1);
      chk(q, 8'h5a);
    end
    m.start();
    m.xfer({bus_addr_upper, sel, 1'b0}, 1'b1, q, ack);
    m.xfer(lock_signal_config_addr, 1'b1, q, ack);
    repeat (4) m.bit_x(1'b0, ack);
    m.stop();
    rd(lock_signal_config_addr, 1);
    chk(q, 8'h5a);
    wr(recovery_control_addr, 8'h00, 8'h00, 2);
    rd(lock_signal_config_addr, 1);
    chk(q, 8'h00);
    pulse(8'h01, 8'h00);
    wr(lock_signal_config_addr, 8'h10, 8'h00, 1);
    chk({7'h0, lock_lost_indicator}, 8'h01);
    wr(recovery_control_addr, 8'h04, 8'h00, 1);
    rd(lock_status_addr, 1);
    chk(q & 8'h05, 8'h05);
    wr(recovery_control_addr, 8'h00, 8'h00, 1);
    wr(lock_status_addr, 8'hff, 8'h00, 1);
    rd(lock_status_addr, 1);
    chk(q & 8'h05, 8'h01);
    pulse(8'h01, 8'h01);
    rd(lock_status_addr, 1);
    chk(q & 8'h05, 8'h05);
    harm = 1'b1;
    repeat (16) @(negedge mclk);
    chk({7'h0, frc}, 8'h01);
    wr(recovery_control_addr, {1'b0, mode_reference_locked, 4'h0}, 8'h00, 1);
    wr(reference_buffer_addr, 8'h01, 8'h00, 1);
    repeat (16) @(negedge mclk);
    chk({7'h0, frc}, 8'h00);
    chk({5'h0, mode}, {5'h0, mode_reference_locked});
    chk({7'h0, rpd}, 8'h00);
    wr(recovery_control_addr, 8'h02, 8'h00, 1);
    repeat (16) @(negedge mclk);
    chk({6'h0, rme, frc}, 8'h03);
    for (int k = 0; k < 5; k++) begin
      wr(output_driver_addr, ov[k], 8'h00, 1);
      chk({5'h0, doff, coff, dout}, ex[k]);
    end
    rd(output_driver_addr, 3);
    chk(q, 8'h02);
    report_and_stop();
  end
endmodule
